//--- logic/sslmc_defs.vh
// Constants for the supply supervisor low-power mode control block
// Contract
// [RULE1] With the core supervisor enable at 0 the core supervisor is off in every mode and deep-sleep wake-up is fast.
// [RULE2] Under manual core control an enabled core supervisor goes off in deep sleep when its sleep mode bit is 0, else keeps its active state.
// [RULE3] Under automatic core control the core supervisor is off in deep sleep unless sleep mode and full performance are both 1, then it runs normal.
// [RULE4] An enabled core supervisor without full performance gives the slow wake-up of about 150 us, with full performance the fast one.
// [RULE5] An enabled core monitor runs normal or full in active mode, keeps that in deep sleep when manual, and when automatic is off or normal if full.
// [RULE6] The input supervisor decodes like the core one with its own auto bit and goes off in deep sleep when its mode bit is 0,
// or when auto is set and its full performance bit is 0.
// [RULE7] An enabled input monitor without full performance runs normal, goes off in deep sleep under auto and keeps its state under manual.
// [RULE8] After a write to either control register software waits until both settle flags read 0 before deep sleep.
// [RULE9] Software may clear the core supervisor full performance bit to get slow wake-up at longer exit latency.
// [RULE10] Software may keep the input supervisor and monitor manual and on in deep sleep at higher sleep current.
// [RULE11] A configuration is affected when the core side is fast or off and an input unit in normal would go off in deep sleep; the check reads 1 then.
// [RULE12] Software may add a 150 us delay in the handler or before the deepest sleep modes when fast servicing is needed.
// [RULE13] In an affected configuration a wake within 1 us of deep-sleep entry may leave the device stuck until a reset.
`ifndef SSLMC_DEFS_VH
`define SSLMC_DEFS_VH

// APB register offsets
`define SSLMC_ADDR_W          8
`define SSLMC_OFF_CORE_CTRL   8'h00
`define SSLMC_OFF_INPUT_CTRL  8'h04
`define SSLMC_OFF_FLAGS       8'h08
`define SSLMC_OFF_INT_STATUS  8'h0C
`define SSLMC_OFF_INT_CLEAR   8'h10
`define SSLMC_OFF_INT_ENABLE  8'h14

// Control register fields, same layout for both sides
`define SSLMC_CTRL_W          6
`define SSLMC_CTRL_RESET      6'h00
`define SSLMC_B_SUP_EN        0
`define SSLMC_B_SUP_MD        1
`define SSLMC_B_SUP_FP        2
`define SSLMC_B_MON_EN        3
`define SSLMC_B_MON_FP        4
`define SSLMC_B_AUTO          5

// Flags register fields
`define SSLMC_F_CORE_SETTLE   0
`define SSLMC_F_INPUT_SETTLE  1
`define SSLMC_F_AFFECTED      2
`define SSLMC_F_DEEP          3
`define SSLMC_F_SLOW_WAKE     4
`define SSLMC_F_LOCKED        5

// Interrupt events
`define SSLMC_EV_W            5
`define SSLMC_EV_RESET        5'h00
`define SSLMC_EV_SETTLED      0
`define SSLMC_EV_DEEP_ENTRY   1
`define SSLMC_EV_WAKE_DONE    2
`define SSLMC_EV_EARLY_ENTRY  3
`define SSLMC_EV_WAKE_HAZARD  4

// Unit operating states
`define SSLMC_ST_OFF          2'h0
`define SSLMC_ST_NORMAL       2'h1
`define SSLMC_ST_FULL         2'h2

// Timing in 20 ns clock cycles
`define SSLMC_CNT_W           16
`define SSLMC_CYC_SLOW        16'h1D4C  // 150 us
`define SSLMC_CYC_SETTLE_FAST 16'h0064  // 2 us
`define SSLMC_CYC_WAKE_FAST   16'h0032  // 1 us
`define SSLMC_CYC_HAZARD      16'h0032  // 1 us

`endif

//--- logic/sslmc_unit_decode.v
// Operating state decoder for one supervisor or monitor
`timescale 1ns/10ps
module sslmc_unit_decode (
    // Configuration
    input  wire       enable,
    input  wire       sleep_mode_bit,
    input  wire       full_perf,
    input  wire       auto_control,
    // Power mode
    input  wire       is_deep,
    // Decoded state
    output reg  [1:0] unit_state
);
`include "sslmc_defs.vh"

    always @* begin
        unit_state = `SSLMC_ST_OFF;
        if (!enable) begin
            unit_state = `SSLMC_ST_OFF;                                    // [RULE1]
        end else if (!is_deep) begin
            unit_state = full_perf ? `SSLMC_ST_FULL : `SSLMC_ST_NORMAL;   // [RULE5]
        end else if (auto_control) begin
            if (sleep_mode_bit && full_perf) begin
                unit_state = `SSLMC_ST_NORMAL;                             // [RULE3]
            end else begin
                unit_state = `SSLMC_ST_OFF;                                // [RULE3]
            end
        end else if (sleep_mode_bit) begin
            unit_state = full_perf ? `SSLMC_ST_FULL : `SSLMC_ST_NORMAL;   // [RULE2]
        end else begin
            unit_state = `SSLMC_ST_OFF;                                    // [RULE2]
        end
    end

endmodule // sslmc_unit_decode

//--- logic/sslmc_top.v
// Supply supervisor low-power mode control with APB registers
`timescale 1ns/10ps
`include "sslmc_defs.vh"
module sslmc_top #(
    parameter [15:0] SETTLE_SLOW_CYC = `SSLMC_CYC_SLOW,
    parameter [15:0] WAKE_SLOW_CYC   = `SSLMC_CYC_SLOW
) (
    // Clock, reset, enable
    input  wire        pclk,
    input  wire        presetn,
    input  wire        clk_en,
    // APB slave
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [7:0]  paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    // Power mode requests from pins
    input  wire        deep_sleep_req,
    input  wire        wake_req,
    // Unit states
    output reg  [1:0]  core_supply_supervisor,
    output reg  [1:0]  core_supply_monitor,
    output reg  [1:0]  input_supply_supervisor,
    output reg  [1:0]  input_supply_monitor,
    // Status
    output reg         deep_sleep_active,
    output reg         slow_wake,
    output reg         core_side_settle_flag,
    output reg         input_side_settle_flag,
    output reg         affected_config_check,
    output reg         wake_locked,
    output reg         irq
);

    // Power mode states
    localparam [1:0] PM_ACTIVE = 2'h0;
    localparam [1:0] PM_DEEP   = 2'h1;
    localparam [1:0] PM_WAKING = 2'h2;

    // Affected configuration check
    function affected_fn;
        input [5:0] lo;
        input [5:0] hi;
        reg         lo_fast;
        reg         hi_off;
        begin
            lo_fast = !lo[`SSLMC_B_SUP_EN] || lo[`SSLMC_B_SUP_FP]
                   || !lo[`SSLMC_B_MON_EN] || lo[`SSLMC_B_MON_FP];
            hi_off  = (hi[`SSLMC_B_SUP_EN] && !hi[`SSLMC_B_SUP_FP]
                       && (!hi[`SSLMC_B_SUP_MD] || hi[`SSLMC_B_AUTO]))
                   || (hi[`SSLMC_B_MON_EN] && !hi[`SSLMC_B_MON_FP] && hi[`SSLMC_B_AUTO]);
            affected_fn = lo_fast && hi_off;
        end
    endfunction

    // Settle length for a side
    function [15:0] settle_len;
        input [5:0]  ctrl;
        input [15:0] slow_cyc;
        begin
            if (ctrl[`SSLMC_B_SUP_FP]) begin
                settle_len = `SSLMC_CYC_SETTLE_FAST;
            end else begin
                settle_len = slow_cyc;
            end
        end
    endfunction

    // Registers
    reg  [5:0]  core_side_supervisor_control;
    reg  [5:0]  input_side_supervisor_control;
    reg  [4:0]  int_status;
    reg  [4:0]  int_enable;
    reg  [1:0]  power_mode;
    reg  [15:0] core_settle_cnt;
    reg  [15:0] input_settle_cnt;
    reg  [15:0] wake_cnt;
    reg  [15:0] entry_cnt;
    reg         sleep_meta;
    reg         sleep_sync;
    reg         wake_meta;
    reg         wake_sync;

    // Combinational
    reg  [4:0]  next_int_status;
    reg  [4:0]  events;
    reg  [1:0]  next_power_mode;
    reg  [15:0] next_core_settle_cnt;
    reg  [15:0] next_input_settle_cnt;
    reg  [15:0] next_wake_cnt;
    reg  [15:0] next_entry_cnt;
    reg         next_locked;
    reg  [31:0] next_prdata;
    reg         next_pslverr;
    wire        wr_access;
    wire        wr_core;
    wire        wr_input;
    wire        is_deep;
    wire        affected;
    wire [1:0]  dec_core_sup;
    wire [1:0]  dec_core_mon;
    wire [1:0]  dec_input_sup;
    wire [1:0]  dec_input_mon;

    assign wr_access = psel && penable && pready && pwrite;
    assign wr_core   = wr_access && (paddr == `SSLMC_OFF_CORE_CTRL);
    assign wr_input  = wr_access && (paddr == `SSLMC_OFF_INPUT_CTRL);
    assign is_deep   = (power_mode != PM_ACTIVE);
    assign affected  = affected_fn(core_side_supervisor_control, input_side_supervisor_control);  // [RULE11]

    sslmc_unit_decode u_core_sup (
        .enable         (core_side_supervisor_control[`SSLMC_B_SUP_EN]),
        .sleep_mode_bit (core_side_supervisor_control[`SSLMC_B_SUP_MD]),
        .full_perf      (core_side_supervisor_control[`SSLMC_B_SUP_FP]),
        .auto_control   (core_side_supervisor_control[`SSLMC_B_AUTO]),
        .is_deep        (is_deep),
        .unit_state     (dec_core_sup)
    );

    // Monitor behaves as a supervisor whose sleep mode bit is held at 1
    sslmc_unit_decode u_core_mon (
        .enable         (core_side_supervisor_control[`SSLMC_B_MON_EN]),
        .sleep_mode_bit (1'b1),
        .full_perf      (core_side_supervisor_control[`SSLMC_B_MON_FP]),
        .auto_control   (core_side_supervisor_control[`SSLMC_B_AUTO]),
        .is_deep        (is_deep),
        .unit_state     (dec_core_mon)
    );

    sslmc_unit_decode u_input_sup (
        .enable         (input_side_supervisor_control[`SSLMC_B_SUP_EN]),
        .sleep_mode_bit (input_side_supervisor_control[`SSLMC_B_SUP_MD]),
        .full_perf      (input_side_supervisor_control[`SSLMC_B_SUP_FP]),
        .auto_control   (input_side_supervisor_control[`SSLMC_B_AUTO]),
        .is_deep        (is_deep),
        .unit_state     (dec_input_sup)
    );

    sslmc_unit_decode u_input_mon (
        .enable         (input_side_supervisor_control[`SSLMC_B_MON_EN]),
        .sleep_mode_bit (1'b1),
        .full_perf      (input_side_supervisor_control[`SSLMC_B_MON_FP]),
        .auto_control   (input_side_supervisor_control[`SSLMC_B_AUTO]),
        .is_deep        (is_deep),
        .unit_state     (dec_input_mon)
    );

    // Power mode, settle and wake timing
    always @* begin
        events                = `SSLMC_EV_RESET;
        next_power_mode       = power_mode;
        next_wake_cnt         = wake_cnt;
        next_entry_cnt        = entry_cnt;
        next_locked           = wake_locked;
        next_core_settle_cnt  = core_settle_cnt;
        next_input_settle_cnt = input_settle_cnt;
        if (wr_core) begin
            next_core_settle_cnt = settle_len(pwdata[5:0], SETTLE_SLOW_CYC);                  // [RULE8]
        end else if (core_settle_cnt != 16'h0000) begin
            next_core_settle_cnt = core_settle_cnt - 16'h0001;
        end
        if (wr_input) begin
            next_input_settle_cnt = settle_len(pwdata[5:0], SETTLE_SLOW_CYC);                 // [RULE8]
        end else if (input_settle_cnt != 16'h0000) begin
            next_input_settle_cnt = input_settle_cnt - 16'h0001;
        end
        if ((core_settle_cnt != 16'h0000 || input_settle_cnt != 16'h0000)
            && next_core_settle_cnt == 16'h0000 && next_input_settle_cnt == 16'h0000) begin
            events[`SSLMC_EV_SETTLED] = 1'b1;
        end
        case (power_mode)
            PM_ACTIVE: begin
                if (sleep_sync) begin
                    next_power_mode                 = PM_DEEP;
                    next_entry_cnt                  = 16'h0000;
                    events[`SSLMC_EV_DEEP_ENTRY]    = 1'b1;
                    if (core_side_settle_flag || input_side_settle_flag) begin
                        events[`SSLMC_EV_EARLY_ENTRY] = 1'b1;                                  // [RULE8]
                    end
                end
            end
            PM_DEEP: begin
                if (entry_cnt != 16'hFFFF) begin
                    next_entry_cnt = entry_cnt + 16'h0001;
                end
                if (wake_sync && !wake_locked) begin
                    if (affected && entry_cnt < `SSLMC_CYC_HAZARD) begin
                        events[`SSLMC_EV_WAKE_HAZARD] = 1'b1;                                  // [RULE13]
                        next_locked                   = 1'b1;                                  // [RULE13]
                    end else begin
                        next_power_mode = PM_WAKING;
                        if (slow_wake) begin
                            next_wake_cnt = WAKE_SLOW_CYC;                                     // [RULE4]
                        end else begin
                            next_wake_cnt = `SSLMC_CYC_WAKE_FAST;                              // [RULE1]
                        end
                    end
                end
            end
            PM_WAKING: begin
                if (wake_cnt <= 16'h0001) begin
                    next_power_mode              = PM_ACTIVE;
                    next_wake_cnt                = 16'h0000;
                    events[`SSLMC_EV_WAKE_DONE]  = 1'b1;
                end else begin
                    next_wake_cnt = wake_cnt - 16'h0001;
                end
            end
            default: begin
                next_power_mode = PM_ACTIVE;
            end
        endcase
    end

    // Sticky status, set wins over clear
    always @* begin
        next_int_status = int_status | events;
        if (wr_access && paddr == `SSLMC_OFF_INT_CLEAR) begin
            next_int_status = (int_status & ~pwdata[4:0]) | events;
        end
    end

    // Read decode, captured in the setup cycle
    always @* begin
        next_prdata  = 32'h00000000;
        next_pslverr = 1'b0;
        case (paddr)
            `SSLMC_OFF_CORE_CTRL:  next_prdata[5:0] = core_side_supervisor_control;
            `SSLMC_OFF_INPUT_CTRL: next_prdata[5:0] = input_side_supervisor_control;
            `SSLMC_OFF_FLAGS: begin
                next_prdata[`SSLMC_F_CORE_SETTLE]  = core_side_settle_flag;
                next_prdata[`SSLMC_F_INPUT_SETTLE] = input_side_settle_flag;
                next_prdata[`SSLMC_F_AFFECTED]     = affected_config_check;                     // [RULE11]
                next_prdata[`SSLMC_F_DEEP]         = deep_sleep_active;
                next_prdata[`SSLMC_F_SLOW_WAKE]    = slow_wake;
                next_prdata[`SSLMC_F_LOCKED]       = wake_locked;
            end
            `SSLMC_OFF_INT_STATUS: next_prdata[4:0] = int_status;
            `SSLMC_OFF_INT_CLEAR:  next_prdata      = 32'h00000000;
            `SSLMC_OFF_INT_ENABLE: next_prdata[4:0] = int_enable;
            default:               next_pslverr     = 1'b1;
        endcase
    end

    // Pin synchronisers
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sleep_meta <= 1'b0;
            sleep_sync <= 1'b0;
            wake_meta  <= 1'b0;
            wake_sync  <= 1'b0;
        end else if (clk_en) begin
            sleep_meta <= deep_sleep_req;
            sleep_sync <= sleep_meta;
            wake_meta  <= wake_req;
            wake_sync  <= wake_meta;
        end
    end

    // State registers
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            core_side_supervisor_control  <= `SSLMC_CTRL_RESET;
            input_side_supervisor_control <= `SSLMC_CTRL_RESET;
            int_status                    <= `SSLMC_EV_RESET;
            int_enable                    <= `SSLMC_EV_RESET;
            power_mode                    <= PM_ACTIVE;
            core_settle_cnt               <= 16'h0000;
            input_settle_cnt              <= 16'h0000;
            wake_cnt                      <= 16'h0000;
            entry_cnt                     <= 16'h0000;
            prdata                        <= 32'h00000000;
            pready                        <= 1'b0;
            pslverr                       <= 1'b0;
            core_supply_supervisor        <= `SSLMC_ST_OFF;
            core_supply_monitor           <= `SSLMC_ST_OFF;
            input_supply_supervisor       <= `SSLMC_ST_OFF;
            input_supply_monitor          <= `SSLMC_ST_OFF;
            deep_sleep_active             <= 1'b0;
            slow_wake                     <= 1'b0;
            core_side_settle_flag         <= 1'b0;
            input_side_settle_flag        <= 1'b0;
            affected_config_check         <= 1'b0;
            wake_locked                   <= 1'b0;
            irq                           <= 1'b0;
        end else if (clk_en) begin
            if (wr_core) begin
                core_side_supervisor_control <= pwdata[5:0];
            end
            if (wr_input) begin
                input_side_supervisor_control <= pwdata[5:0];
            end
            if (wr_access && paddr == `SSLMC_OFF_INT_ENABLE) begin
                int_enable <= pwdata[4:0];
            end
            int_status       <= next_int_status;
            irq              <= |(next_int_status & int_enable);
            power_mode       <= next_power_mode;
            core_settle_cnt  <= next_core_settle_cnt;
            input_settle_cnt <= next_input_settle_cnt;
            wake_cnt         <= next_wake_cnt;
            entry_cnt        <= next_entry_cnt;
            wake_locked      <= next_locked;
            pready           <= psel && !penable;
            if (psel && !penable) begin
                prdata  <= next_prdata;
                pslverr <= next_pslverr;
            end
            core_supply_supervisor  <= dec_core_sup;                                          // [RULE2]
            core_supply_monitor     <= dec_core_mon;                                          // [RULE5]
            input_supply_supervisor <= dec_input_sup;                                         // [RULE6]
            input_supply_monitor    <= dec_input_mon;                                         // [RULE7]
            deep_sleep_active       <= is_deep;
            slow_wake               <= core_side_supervisor_control[`SSLMC_B_SUP_EN]
                                    && !core_side_supervisor_control[`SSLMC_B_SUP_FP];        // [RULE4]
            core_side_settle_flag   <= (next_core_settle_cnt != 16'h0000);                    // [RULE8]
            input_side_settle_flag  <= (next_input_settle_cnt != 16'h0000);                   // [RULE8]
            affected_config_check   <= affected;                                              // [RULE11]
        end
    end

endmodule // sslmc_top

//--- dv/sslmc_monitor.sv
// Concurrent checks on the supply supervisor mode control ports
`timescale 1ns/10ps
module sslmc_monitor (
    // Clock and reset
    input wire       pclk,
    input wire       presetn,
    // APB
    input wire       psel,
    input wire       penable,
    input wire       pwrite,
    input wire [7:0] paddr,
    input wire       pready,
    // Unit states and status
    input wire [1:0] core_supply_supervisor,
    input wire [1:0] core_supply_monitor,
    input wire [1:0] input_supply_supervisor,
    input wire [1:0] input_supply_monitor,
    input wire       deep_sleep_active,
    input wire       slow_wake,
    input wire       core_side_settle_flag,
    input wire       wake_locked
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    AST_FAST_WHEN_OFF: assert property (!deep_sleep_active && core_supply_supervisor == 2'h0 |-> !slow_wake)
        else $error("slow wake with core supervisor off");
    AST_SLOW_WAKE: assert property (!deep_sleep_active && $stable(core_supply_supervisor)
        |-> slow_wake == (core_supply_supervisor == 2'h1))
        else $error("wake class does not follow core supervisor state");
    AST_CSUP_NOT_UP: assert property ($rose(deep_sleep_active) |-> core_supply_supervisor <= $past(core_supply_supervisor))
        else $error("core supervisor rose on deep entry");
    AST_CMON_NOT_UP: assert property ($rose(deep_sleep_active) |-> core_supply_monitor <= $past(core_supply_monitor))
        else $error("core monitor rose on deep entry");
    AST_ISUP_NOT_UP: assert property ($rose(deep_sleep_active) |-> input_supply_supervisor <= $past(input_supply_supervisor))
        else $error("input supervisor rose on deep entry");
    AST_IMON_NOT_UP: assert property ($rose(deep_sleep_active) |-> input_supply_monitor <= $past(input_supply_monitor))
        else $error("input monitor rose on deep entry");
    AST_LOCK_STICKY: assert property (wake_locked |=> wake_locked && deep_sleep_active)
        else $error("lock released without reset");
    AST_CORE_SETTLE_START: assert property ($rose(core_side_settle_flag)
        |-> $past(psel && penable && pready && pwrite && paddr == 8'h00))
        else $error("core settle flag rose without a control write");
    AST_APB_READY: assert property (psel && !penable |=> pready ##1 !pready)
        else $error("access phase answer not one cycle");

    COV_DEEP: cover property ($rose(deep_sleep_active));
    COV_LOCK: cover property ($rose(wake_locked));
    COV_SLOW: cover property (slow_wake && deep_sleep_active);
endmodule // sslmc_monitor

bind sslmc_top sslmc_monitor sslmc_monitor_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pready(pready), .core_supply_supervisor(core_supply_supervisor), .core_supply_monitor(core_supply_monitor),
    .input_supply_supervisor(input_supply_supervisor), .input_supply_monitor(input_supply_monitor),
    .deep_sleep_active(deep_sleep_active), .slow_wake(slow_wake),
    .core_side_settle_flag(core_side_settle_flag), .wake_locked(wake_locked));

//--- dv/testbench.sv
// Self-checking bench for the supply supervisor mode control block
`timescale 1ns/10ps
`include "sslmc_defs.vh"
module testbench;
    reg         pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, deep_sleep_req = 0, wake_req = 0;
    reg  [7:0]  paddr = 8'h00;
    reg  [31:0] pwdata = 32'h0;
    wire [31:0] prdata;
    wire        pready, pslverr, deep_sleep_active, slow_wake, core_side_settle_flag, input_side_settle_flag;
    wire        affected_config_check, wake_locked, irq;
    wire [1:0]  core_supply_supervisor, core_supply_monitor, input_supply_supervisor, input_supply_monitor;
    int         failures = 0, cmp_count = 0, i, n;
    reg  [15:0] lfsr = 16'h47AF;
    reg  [5:0]  lc, hc;
    reg  [32:0] expq[$];

    sslmc_top #(.SETTLE_SLOW_CYC(16'h0014), .WAKE_SLOW_CYC(16'h0078)) sslmc_top_i (
        .pclk(pclk), .presetn(presetn), .clk_en(1'b1), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .deep_sleep_req(deep_sleep_req), .wake_req(wake_req), .core_supply_supervisor(core_supply_supervisor),
        .core_supply_monitor(core_supply_monitor), .input_supply_supervisor(input_supply_supervisor),
        .input_supply_monitor(input_supply_monitor), .deep_sleep_active(deep_sleep_active), .slow_wake(slow_wake),
        .core_side_settle_flag(core_side_settle_flag), .input_side_settle_flag(input_side_settle_flag),
        .affected_config_check(affected_config_check), .wake_locked(wake_locked), .irq(irq));

    initial begin
        forever #10 pclk = ~pclk;
    end

    function [15:0] lfsr_next(input [15:0] s);
        lfsr_next = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    // Expected unit state from enable, sleep mode, full performance, auto and deep
    function [1:0] dec(input en, input md, input fp, input au, input dp);
        if (!en) dec = 2'h0;
        else if (!dp) dec = fp ? 2'h2 : 2'h1;
        else if (au) dec = (md && fp) ? 2'h1 : 2'h0;
        else dec = md ? (fp ? 2'h2 : 2'h1) : 2'h0;
    endfunction
    function aff(input [5:0] l, input [5:0] h);
        aff = (!l[0] || l[2] || !l[3] || l[4]) && ((h[0] && !h[2] && (!h[1] || h[5])) || (h[3] && !h[4] && h[5]));
    endfunction

    task check_val(input [31:0] got, input [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("Error at %0t: value %h expected %h", $time, got, exp);
        end
    endtask
    task check_rd(input [32:0] got, input [32:0] exp);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("Error at %0t: read %h expected %h", $time, got, exp);
        end
    endtask
    task apb(input w, input [7:0] a, input [31:0] d);
        @(posedge pclk);
        psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        do @(posedge pclk); while (pready !== 1'b1);
        psel <= 0; penable <= 0;
    endtask
    task rd(input [7:0] a, input [32:0] e);
        expq.push_back(e);
        apb(0, a, 32'h0);
    endtask
    task settle;
        do @(posedge pclk); while (core_side_settle_flag !== 0 || input_side_settle_flag !== 0);
    endtask
    task wait_deep(input v);
        n = 0;
        do begin @(posedge pclk); n++; end while (deep_sleep_active !== v);
    endtask
    task go_deep;
        deep_sleep_req <= 1;
        wait_deep(1);
        deep_sleep_req <= 0;
    endtask
    task chk4(input dp);
        check_val(core_supply_supervisor, dec(lc[0], lc[1], lc[2], lc[5], dp));
        check_val(core_supply_monitor, dec(lc[3], 1'b1, lc[4], lc[5], dp));
        check_val(input_supply_supervisor, dec(hc[0], hc[1], hc[2], hc[5], dp));
        check_val(input_supply_monitor, dec(hc[3], 1'b1, hc[4], hc[5], dp));
    endtask
    task tally_and_finish;
        $display("Counts: %0d compares, %0d failures", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    // Read results taken off the queue as they complete
    always @(posedge pclk) begin
        if (psel && penable && pready === 1'b1 && !pwrite) begin
            if (expq.size() == 0) begin
                failures++;
                $display("Error at %0t: unexpected read", $time);
            end else check_rd({pslverr, prdata}, expq.pop_front());
        end
    end

    initial begin
        repeat (60000) @(posedge pclk);
        failures++;
        $display("Error at %0t: watchdog expired", $time);
        tally_and_finish;
    end

    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1;
        for (i = 0; i < 6; i++) rd(i * 4, 33'h0);
        rd(8'h18, {1'b1, 32'h0});
        check_val(slow_wake, 0);
        $display("Test reset values done");
        for (i = 0; i < 16; i++) begin
            lfsr = lfsr_next(lfsr);
            lc = lfsr[5:0];
            hc = lfsr[11:6];
            apb(1, `SSLMC_OFF_CORE_CTRL, {26'h0, lc});
            apb(1, `SSLMC_OFF_INPUT_CTRL, {26'h0, hc});
            settle;
            chk4(0);
            rd(`SSLMC_OFF_FLAGS, {28'h0, lc[0] && !lc[2], 1'b0, aff(lc, hc), 2'h0});
            go_deep;
            chk4(1);
            repeat (60) @(posedge pclk);
            wake_req <= 1;
            wait_deep(0);
            wake_req <= 0;
            check_val(n > 90, lc[0] && !lc[2]);
        end
        $display("Test mode decoding done");
        rd(`SSLMC_OFF_INT_STATUS, 33'h07);
        apb(1, `SSLMC_OFF_INT_ENABLE, 32'h07);
        repeat (2) @(posedge pclk);
        check_val(irq, 1);
        apb(1, `SSLMC_OFF_INT_CLEAR, 32'h1F);
        rd(`SSLMC_OFF_INT_STATUS, 33'h0);
        repeat (2) @(posedge pclk);
        check_val(irq, 0);
        apb(1, `SSLMC_OFF_INT_ENABLE, 32'h08);
        apb(1, `SSLMC_OFF_CORE_CTRL, 32'h05);
        go_deep;
        repeat (2) @(posedge pclk);
        check_val(irq, 1);
        rd(`SSLMC_OFF_INT_STATUS, 33'h0A);
        apb(1, `SSLMC_OFF_INT_ENABLE, 32'h0);
        repeat (2) @(posedge pclk);
        check_val(irq, 0);
        repeat (60) @(posedge pclk);
        wake_req <= 1;
        wait_deep(0);
        wake_req <= 0;
        $display("Test interrupts done");
        apb(1, `SSLMC_OFF_CORE_CTRL, 32'h00);
        apb(1, `SSLMC_OFF_INPUT_CTRL, 32'h01);
        settle;
        go_deep;
        wake_req <= 1;
        repeat (20) @(posedge pclk);
        wake_req <= 0;
        check_val({wake_locked, deep_sleep_active}, 2'h3);
        rd(`SSLMC_OFF_FLAGS, 33'h2C);
        presetn <= 0;
        repeat (3) @(posedge pclk);
        presetn <= 1;
        @(posedge pclk);
        check_val({wake_locked, deep_sleep_active}, 2'h0);
        $display("Test wake hazard done");
        for (i = 0; i < 2; i++) begin
            apb(1, `SSLMC_OFF_CORE_CTRL, i ? 32'h00 : 32'h09);
            apb(1, `SSLMC_OFF_INPUT_CTRL, i ? 32'h03 : 32'h01);
            settle;
            go_deep;
            wake_req <= 1;
            wait_deep(0);
            wake_req <= 0;
            check_val({wake_locked, n > 90}, {1'b0, i == 0});
        end
        $display("Test workarounds done");
        tally_and_finish;
    end
endmodule // testbench
